// ===== rtl/pwc_pkg.sv
// Shared types and constants of the eight-channel waveform timer block.
package pwc_pkg;

  // Number of 8-bit channels and the width of one register byte.
  localparam int PWC_NUM_CH = 8;
  localparam int PWC_BYTE_W = 8;
  // Width of a joined channel pair.
  localparam int PWC_WIDE_W = 16;
  // Number of channel pairs that can be joined.
  localparam int PWC_NUM_PAIR = 4;

  // Reset values of counter direction, output flip-flop and shutdown flag.
  localparam logic PWC_DIR_UP_RST = 1'h0;
  localparam logic PWC_WAVE_RST   = 1'h0;
  localparam logic PWC_FLAG_RST   = 1'h0;

  // Per-channel settings that software holds in its control bits.
  typedef struct packed {
    logic channel_enable_bit;   // Channel runs while set.
    logic center_align_sel;     // Set selects center-aligned mode.
    logic channel_polarity_bit; // Set starts each cycle high.
    logic channel_clock_sel;    // Set selects the scaled clock.
  } pwc_chan_cfg_type;

  // One write cycle towards a channel's period, duty or counter byte.
  typedef struct packed {
    logic       period_wr;  // Write data to the period buffer.
    logic       duty_wr;    // Write data to the duty buffer.
    logic       counter_wr; // Any write clears the counter.
    logic [7:0] data;       // Byte written.
  } pwc_chan_wr_type;

  // Prescaled clock enables, each a one-cycle pulse.
  typedef struct packed {
    logic tick_a;
    logic tick_sa;
    logic tick_b;
    logic tick_sb;
  } pwc_ticks_type;

endpackage

// ===== rtl/pwc_timers.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - Alignment bit clear: left-aligned, counting up only.
// - Left-aligned: duty match toggles output flip-flop.
// - Period match clears counter, flip-flop, loads buffers.
// - Left-aligned count runs zero to period minus one.
// - Left frequency is clock over period.
// - Alignment bit set: up/down, up at zero.
// - Period match turns down; duty toggles both ways.
// - Down count reaching zero turns up, loads buffers.
// - Center-aligned effective period is twice period.
// - Four join bits pair channels into 16 bits.
// - Even channel supplies high-order bytes.
// - Odd channel gives clock, polarity, output pin.
// - Odd enable rules pair; even output disabled.
// - Any counter byte write clears whole counter.
// - Joined pair follows odd channel alignment.
// - Boundary duty and period give constant output.
// - Reset: counting up, disabled, counters stopped.
// - Channel seven changes set the shutdown flag.
// - Stop or halted wait: force outputs, no flag.
// - Only raise the interrupt, never service it.
// - Polarity set starts high, low at duty.
// - Enabled channel loads new values at period end.
// - Counter write clears, counts up, loads buffers.
module pwc_timers (
  input  wire logic                     clock_i,
  input  wire logic                     rst_b_i,
  input  wire pwc_pkg::pwc_ticks_type   ticks_i,
  input  wire pwc_pkg::pwc_chan_cfg_type [7:0] chan_cfg_i,
  input  wire pwc_pkg::pwc_chan_wr_type [7:0]  chan_wr_i,
  input  wire logic [3:0]               concat_control_i,
  input  wire logic                     channel_seven_pin_i,
  input  wire logic                     ch7_shutdown_input_en_i,
  input  wire logic                     shutdown_active_level_i,
  input  wire logic                     shutdown_output_level_i,
  input  wire logic                     shutdown_irq_enable_i,
  input  wire logic                     shutdown_flag_clear_i,
  input  wire logic                     stop_mode_i,
  input  wire logic                     wait_mode_i,
  input  wire logic                     halt_in_wait_bit_i,
  output logic [7:0]                    channel_output_pin_o,
  output logic [7:0]                    channel_output_en_o,
  output logic [7:0][7:0]               channel_counter_o,
  output logic                          emergency_shutdown_active_o,
  output logic                          shutdown_irq_flag_o,
  output logic                          shutdown_irq_o
);
  import pwc_pkg::*;

  // Picks a channel's clock enable: channels 0, 1, 4 and 5 use A or SA,
  // the others B or SB.
  function automatic logic pwc_tick_sel(input int ch, input logic scaled,
                                         input pwc_ticks_type t);
    logic group_a;
    group_a = (ch % 4) < 2;
    if (group_a) begin
      return scaled ? t.tick_sa : t.tick_a;
    end else begin
      return scaled ? t.tick_sb : t.tick_b;
    end
  endfunction

  logic [7:0]       narrow_wave;   // Waveforms of the single channels.
  logic [7:0][7:0]  narrow_cnt;    // Counters of the single channels.
  logic [3:0]       wide_wave;     // Waveforms of the joined pairs.
  logic [3:0][15:0] wide_cnt;      // Counters of the joined pairs.
  logic [7:0]       pin_next;      // Pin levels before shutdown forcing.
  logic [7:0]       pin_en_next;   // Pin enables before shutdown.
  logic [7:0][7:0]  cnt_out_next;  // Counter readback per channel.

  // Channel-seven pin synchroniser; stage one feeds only stage two.
  logic seven_s1_reg;
  logic seven_s2_reg;
  logic seven_s3_reg;              // Previous synchronised level, for change detection.
  logic [2:0] seven_warm_reg;      // Fills with ones as the stages take real pin samples.
  logic shut_active;               // Shutdown in force this cycle.
  logic shut_active_reg;           // Shutdown state of the last cycle.
  logic halted;                    // Low-power state that suppresses the flag.
  logic flag_set;                  // An event that sets the flag.
  logic flag_reg;                  // Sticky shutdown flag.
  logic [7:0] pin_reg;             // Registered pin levels.
  logic [7:0] pin_en_reg;          // Registered pin enables.
  logic [7:0][7:0] cnt_out_reg;    // Registered counter readback.

  // Each pair holds two single engines and one joined engine; the join bit
  // decides which of them runs, so the idle ones hold their count until a counter write clears it.
  for (genvar p = 0; p < PWC_NUM_PAIR; p++) begin : g_pair
    localparam int E = 2 * p;
    localparam int O = 2 * p + 1;
    logic join_pair;
    assign join_pair = concat_control_i[p];

    for (genvar k = 0; k < 2; k++) begin : g_narrow
      localparam int C = E + k;
      pwc_wave_engine #(
        .W (PWC_BYTE_W)
      ) u_narrow (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .tick_i     (pwc_tick_sel(C, chan_cfg_i[C].channel_clock_sel, ticks_i)),
        .enable_i   (chan_cfg_i[C].channel_enable_bit && !join_pair),
        .center_i   (chan_cfg_i[C].center_align_sel),
        .polarity_i (chan_cfg_i[C].channel_polarity_bit),
        .per_wr_i   (chan_wr_i[C].period_wr),
        .dty_wr_i   (chan_wr_i[C].duty_wr),
        .cnt_wr_i   (chan_wr_i[C].counter_wr),
        .wr_data_i  (chan_wr_i[C].data),
        .count_o    (narrow_cnt[C]),
        .wave_o     (narrow_wave[C])
      );
    end

    // Joined engine: even bytes high, odd bytes low; odd channel settings.
    pwc_wave_engine #(
      .W (PWC_WIDE_W)
    ) u_wide (
      .clock_i    (clock_i),
      .rst_b_i    (rst_b_i),
      .tick_i     (pwc_tick_sel(O, chan_cfg_i[O].channel_clock_sel, ticks_i)),
      .enable_i   (chan_cfg_i[O].channel_enable_bit && join_pair),
      .center_i   (chan_cfg_i[O].center_align_sel),
      .polarity_i (chan_cfg_i[O].channel_polarity_bit),
      .per_wr_i   ({chan_wr_i[E].period_wr, chan_wr_i[O].period_wr}),
      .dty_wr_i   ({chan_wr_i[E].duty_wr, chan_wr_i[O].duty_wr}),
      .cnt_wr_i   (chan_wr_i[E].counter_wr || chan_wr_i[O].counter_wr),
      .wr_data_i  ({chan_wr_i[E].data, chan_wr_i[O].data}),
      .count_o    (wide_cnt[p]),
      .wave_o     (wide_wave[p])
    );

    // Output and readback steering for the pair.
    always_comb begin
      if (join_pair) begin
        pin_next[O]     = wide_wave[p];
        pin_next[E]     = 1'h0;
        pin_en_next[O]  = chan_cfg_i[O].channel_enable_bit;
        pin_en_next[E]  = 1'h0;
        cnt_out_next[O] = wide_cnt[p][7:0];
        cnt_out_next[E] = wide_cnt[p][15:8];
      end else begin
        pin_next[O]     = narrow_wave[O];
        pin_next[E]     = narrow_wave[E];
        pin_en_next[O]  = chan_cfg_i[O].channel_enable_bit;
        pin_en_next[E]  = chan_cfg_i[E].channel_enable_bit;
        cnt_out_next[O] = narrow_cnt[O];
        cnt_out_next[E] = narrow_cnt[E];
      end
    end
  end

  // Two-stage synchroniser plus one history stage for the pin. The stages reset
  // to low, not to the pin's idle level, so the warm-up bits keep the reset
  // value from passing for a pin change or a shutdown level.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seven_s1_reg   <= 1'h0;
      seven_s2_reg   <= 1'h0;
      seven_s3_reg   <= 1'h0;
      seven_warm_reg <= 3'h0;
    end else begin
      seven_s1_reg   <= channel_seven_pin_i;
      seven_s2_reg   <= seven_s1_reg;
      seven_s3_reg   <= seven_s2_reg;
      seven_warm_reg <= {seven_warm_reg[1:0], 1'h1};
    end
  end

  // Shutdown holds while the input function is on and the pin sits at its
  // active level; the forcing works in every power mode.
  assign shut_active = ch7_shutdown_input_en_i && seven_warm_reg[1] &&
                       (seven_s2_reg == shutdown_active_level_i);
  assign halted      = stop_mode_i || (wait_mode_i && halt_in_wait_bit_i);
  assign flag_set    = !halted && ch7_shutdown_input_en_i &&
                       ((seven_warm_reg[2] && (seven_s2_reg != seven_s3_reg)) ||
                        (shut_active && !shut_active_reg));

  // Sticky flag; a set in the cycle of a clear wins so no event is lost.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_reg        <= PWC_FLAG_RST;
      shut_active_reg <= 1'h0;
    end else begin
      flag_reg        <= flag_set || (flag_reg && !shutdown_flag_clear_i);
      shut_active_reg <= shut_active;
    end
  end

  // Registered pins and readback; shutdown overrides every channel level.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_reg     <= '0;
      pin_en_reg  <= '0;
      cnt_out_reg <= '0;
    end else begin
      pin_reg     <= shut_active ? {8{shutdown_output_level_i}} : pin_next;
      // The channel-seven pin turns input while its shutdown function is on.
      pin_en_reg  <= pin_en_next & {!ch7_shutdown_input_en_i, 7'h7f};
      cnt_out_reg <= cnt_out_next;
    end
  end

  assign channel_output_pin_o        = pin_reg;
  assign channel_output_en_o         = pin_en_reg;
  assign channel_counter_o           = cnt_out_reg;
  assign emergency_shutdown_active_o = shut_active_reg;
  assign shutdown_irq_flag_o         = flag_reg;
  // The request is only raised; clearing it is up to software.
  assign shutdown_irq_o              = flag_reg && shutdown_irq_enable_i;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // A write to either byte of the joined pair zero counter.
  sequence s_join_cnt_wr;
    concat_control_i[0] && (chan_wr_i[0].counter_wr || chan_wr_i[1].counter_wr);
  endsequence

  flag_set_a: assert property (
    ch7_shutdown_input_en_i && !halted && seven_warm_reg[2] && $changed(seven_s2_reg)
      |=> flag_reg
  ) else $error("pin change did not set flag");
  halt_noflag_a: assert property (
    halted && !flag_reg |=> !flag_reg
  ) else $error("flag set while halted");
  irq_gate_a: assert property (
    shutdown_irq_o |-> flag_reg && shutdown_irq_enable_i
  ) else $error("interrupt without enabled flag");
  set_wins_a: assert property (
    flag_set && shutdown_flag_clear_i |=> flag_reg
  ) else $error("clear beat a flag event");
  join_off_a: assert property (
    concat_control_i[0] |=> !channel_output_en_o[0]
  ) else $error("high-order output enabled while joined");
  wide_clear_a: assert property (
    s_join_cnt_wr ##1 concat_control_i[0]
      |=> channel_counter_o[0] == 8'h00 && channel_counter_o[1] == 8'h00
  ) else $error("joined counter not cleared");
  shut_force_a: assert property (
    shut_active |=> channel_output_pin_o == {8{$past(shutdown_output_level_i)}}
  ) else $error("shutdown did not force outputs");

endmodule
`default_nettype wire

// ===== rtl/pwc_wave_engine.sv
`timescale 1ns/100ps
`default_nettype none
// One waveform timer of configurable width, used for single and joined channels.
module pwc_wave_engine #(
  parameter int W = 8 // Counter width; a multiple of one byte.
) (
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic         tick_i,
  input  wire logic         enable_i,
  input  wire logic         center_i,
  input  wire logic         polarity_i,
  input  wire logic [W/8-1:0] per_wr_i,
  input  wire logic [W/8-1:0] dty_wr_i,
  input  wire logic         cnt_wr_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic      [W-1:0] count_o,
  output logic              wave_o
);
  import pwc_pkg::*;

  localparam int L = W / PWC_BYTE_W; // Byte lanes of the buffers.

  logic [W-1:0] per_buf_reg, per_buf_next; // Buffered period.
  logic [W-1:0] dty_buf_reg, dty_buf_next; // Buffered duty.
  logic [W-1:0] per_reg, per_next;         // Active period.
  logic [W-1:0] dty_reg, dty_next;         // Active duty.
  logic [W-1:0] cnt_reg, cnt_next;         // Channel counter.
  logic         dir_down_reg, dir_next;    // Counter direction, set while counting down.
  logic         wave_reg, wave_next;       // Pin level after polarity.
  logic         end_evt;                   // Effective period ends.
  logic         ff;                        // Duty-reached flip-flop value.

  // Byte writes land in the buffers at any time.
  always_comb begin
    per_buf_next = per_buf_reg;
    dty_buf_next = dty_buf_reg;
    for (int i = 0; i < L; i++) begin
      if (per_wr_i[i]) begin
        per_buf_next[i*PWC_BYTE_W +: PWC_BYTE_W] = wr_data_i[i*PWC_BYTE_W +: PWC_BYTE_W];
      end
      if (dty_wr_i[i]) begin
        dty_buf_next[i*PWC_BYTE_W +: PWC_BYTE_W] = wr_data_i[i*PWC_BYTE_W +: PWC_BYTE_W];
      end
    end
  end

  // Counter sequencing for both alignments.
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_down_reg;
    end_evt  = 1'h0;
    if (cnt_wr_i) begin
      cnt_next = '0;
      dir_next = PWC_DIR_UP_RST;
    end else if (tick_i && enable_i) begin
      if (per_reg == '0) begin
        cnt_next = '0;
        end_evt  = 1'h1;
      end else if (!center_i) begin
        // Up only; the period match wraps the count back to zero.
        if ({1'h0, cnt_reg} + (W+1)'(1) >= {1'h0, per_reg}) begin
          cnt_next = '0;
          end_evt  = 1'h1;
        end else begin
          cnt_next = cnt_reg + W'(1);
        end
      end else if (!dir_down_reg) begin
        // Up phase; the period match turns the count downward.
        if (cnt_reg >= per_reg) begin
          dir_next = 1'h1;
          cnt_next = cnt_reg - W'(1);
        end else begin
          cnt_next = cnt_reg + W'(1);
        end
      end else if (cnt_reg <= W'(1)) begin
        // Reaching zero turns upward and ends the doubled period.
        cnt_next = '0;
        dir_next = PWC_DIR_UP_RST;
        end_evt  = 1'h1;
      end else begin
        cnt_next = cnt_reg - W'(1);
      end
    end
  end

  // Buffers reach the active values while disabled, on a counter write or at period end.
  always_comb begin
    if (!enable_i || cnt_wr_i || end_evt) begin
      per_next = per_buf_next;
      dty_next = dty_buf_next;
    end else begin
      per_next = per_reg;
      dty_next = dty_reg;
    end
    // The flip-flop sets at the duty match going up and clears at the duty match
    // going down, so center mode toggles on both passes. A duty at or above the
    // period never sets it, even when the center count touches the period value.
    ff        = (dty_next < per_next) &&
                ((center_i && dir_next) ? (cnt_next > dty_next)
                                        : (cnt_next >= dty_next));
    wave_next = polarity_i ? !ff : ff;
  end

  // Buffer and active registers.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      per_buf_reg <= '0;
      dty_buf_reg <= '0;
      per_reg     <= '0;
      dty_reg     <= '0;
    end else begin
      per_buf_reg <= per_buf_next;
      dty_buf_reg <= dty_buf_next;
      per_reg     <= per_next;
      dty_reg     <= dty_next;
    end
  end

  // Counter, direction and output flip-flop.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg      <= '0;
      dir_down_reg <= PWC_DIR_UP_RST;
      wave_reg     <= PWC_WAVE_RST;
    end else begin
      cnt_reg      <= cnt_next;
      dir_down_reg <= dir_next;
      wave_reg     <= wave_next;
    end
  end

  assign count_o = cnt_reg;
  assign wave_o  = wave_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // A tick of an enabled, unwritten counter.
  sequence s_step;
    tick_i && enable_i && !cnt_wr_i && per_reg != '0;
  endsequence

  left_wrap_a: assert property (
    s_step and (!center_i && {1'h0, cnt_reg} + 1 >= per_reg) |=> cnt_reg == '0
  ) else $error("left count did not wrap");
  left_step_a: assert property (
    s_step and (!center_i && {1'h0, cnt_reg} + 1 < per_reg) |=> cnt_reg == W'($past(cnt_reg) + 1)
  ) else $error("left count did not advance");
  center_turn_a: assert property (
    s_step and (center_i && !dir_down_reg && cnt_reg >= per_reg) |=> dir_down_reg
  ) else $error("center count did not turn down");
  center_base_a: assert property (
    s_step and (center_i && dir_down_reg && cnt_reg == W'(1))
      |=> !dir_down_reg && cnt_reg == '0 && per_reg == $past(per_buf_next)
  ) else $error("center count did not turn up and load");
  cnt_clear_a: assert property (
    cnt_wr_i |=> cnt_reg == '0 && !dir_down_reg && dty_reg == $past(dty_buf_next)
  ) else $error("counter write did not clear and load");
  hold_off_a: assert property (
    !enable_i && !cnt_wr_i |=> $stable(cnt_reg)
  ) else $error("disabled counter moved");
  no_period_a: assert property (
    per_reg == '0 && $stable(polarity_i) && $past(rst_b_i) |-> wave_o == polarity_i
  ) else $error("zero period output not constant");

endmodule
`default_nettype wire

// ===== tb/tb_pwm_channel_waveform_timers.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the eight-channel waveform timers, driven through plain ports.
module tb_pwm_channel_waveform_timers;
  import pwc_pkg::*;
  logic                        clock_i;  // Bench clock, 5 ns period.
  logic                        rst_b_i;  // Active-low reset.
  pwc_ticks_type               ticks;    // Held high so every cycle is a count tick.
  pwc_chan_cfg_type [7:0]      cfg;      // Per-channel settings.
  pwc_chan_wr_type [7:0]       wr_s;     // Per-channel write strobes.
  logic [3:0]                  cat;      // Pair join bits.
  logic                        pin7;     // Channel seven pin level.
  logic                        sd_en;    // Shutdown input function on.
  logic                        sd_lvl;   // Pin level meaning shutdown.
  logic                        sd_out;   // Level forced in shutdown.
  logic                        irq_en;   // Interrupt enable.
  logic                        flag_clr; // Flag clear pulse.
  logic                        stop_m;   // Stop mode.
  logic                        wait_m;   // Wait mode.
  logic                        halt_w;   // Halt in wait.
  logic [7:0]                  pin_o;    // Pin levels.
  logic [7:0]                  en_o;     // Pin drive enables.
  logic [7:0][7:0]             cnt_o;    // Counter readback.
  logic                        sd_act;   // Shutdown in force.
  logic                        flag;     // Sticky shutdown flag.
  logic                        irq;      // Interrupt request.
  int                          errors;
  int                          tests_run;
  int                          cycles;
  int                          hi;
  logic [15:0]                 mx;
  logic [7:0]                  snap;
  // Waveform table: center, polarity, period, duty, highs in 80 ticks, top count.
  int c_cen[9] = '{0, 0, 1, 1, 0, 0, 1, 0, 1};
  int c_pol[9] = '{0, 1, 0, 1, 1, 0, 1, 0, 1};
  int c_per[9] = '{4, 4, 4, 4, 4, 4, 0, 0, 4};
  int c_dty[9] = '{1, 1, 1, 1, 0, 0, 2, 2, 5};
  int c_hi[9]  = '{60, 20, 60, 20, 0, 80, 80, 0, 80};
  int c_mx[9]  = '{3, 3, 4, 4, 3, 3, 0, 0, 4};

  pwc_timers uut (
    .clock_i                     (clock_i),
    .rst_b_i                     (rst_b_i),
    .ticks_i                     (ticks),
    .chan_cfg_i                  (cfg),
    .chan_wr_i                   (wr_s),
    .concat_control_i            (cat),
    .channel_seven_pin_i         (pin7),
    .ch7_shutdown_input_en_i     (sd_en),
    .shutdown_active_level_i     (sd_lvl),
    .shutdown_output_level_i     (sd_out),
    .shutdown_irq_enable_i       (irq_en),
    .shutdown_flag_clear_i       (flag_clr),
    .stop_mode_i                 (stop_m),
    .wait_mode_i                 (wait_m),
    .halt_in_wait_bit_i          (halt_w),
    .channel_output_pin_o        (pin_o),
    .channel_output_en_o         (en_o),
    .channel_counter_o           (cnt_o),
    .emergency_shutdown_active_o (sd_act),
    .shutdown_irq_flag_o         (flag),
    .shutdown_irq_o              (irq)
  );

  // Free-running clock.
  initial begin
    clock_i = 1'h0;
    forever #2.5 clock_i = ~clock_i;
  end

  // Hang guard: the whole sequence needs well under this many cycles.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      test_done();
    end
  end

  // Advance n edges and land just after the last one, where inputs change.
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // One compare for every result; four-state case equality.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One byte write: kind 0 period, 1 duty, 2 counter; strobe lasts one cycle.
  task automatic wr(input int ch, input int kind, input logic [7:0] d);
    wr_s[ch].data = d;
    wr_s[ch].period_wr = (kind == 0);
    wr_s[ch].duty_wr = (kind == 1);
    wr_s[ch].counter_wr = (kind == 2);
    step(1);
    wr_s[ch] = '0;
    step(1);
  endtask

  // Counts high cycles of a pin and the largest count seen, optionally as a joined pair.
  task automatic measure(input int ch, input int n, input bit wide);
    logic [15:0] v;
    hi = 0;
    mx = '0;
    repeat (n) begin
      v = wide ? {cnt_o[ch-1], cnt_o[ch]} : {8'h00, cnt_o[ch]};
      if (v > mx) mx = v;
      if (pin_o[ch] === 1'b1) hi++;
      step(1);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    rst_b_i = 1'h0;
    ticks = '1;
    cfg = '0;
    wr_s = '0;
    cat = 4'h0;
    pin7 = 1'h1;
    sd_en = 1'h0;
    sd_lvl = 1'h0;
    sd_out = 1'h1;
    irq_en = 1'h1;
    flag_clr = 1'h0;
    stop_m = 1'h0;
    wait_m = 1'h0;
    halt_w = 1'h0;
    step(4);
    chk({8'h00, cnt_o[0]}, 16'h0000, "counter in reset");
    rst_b_i = 1'h1;
    step(10);
    // With every channel disabled after reset no counter moves.
    chk(cnt_o[0] | cnt_o[3] | cnt_o[7], 8'h00, "counters after reset");
    $display("test reset done");

    // Modes, polarities and boundary values on channel 0, started clean each time.
    for (int i = 0; i < 9; i++) begin
      cfg[0] = '{1'b0, c_cen[i][0], c_pol[i][0], 1'b0};
      step(1);
      wr(0, 0, c_per[i][7:0]);
      wr(0, 1, c_dty[i][7:0]);
      wr(0, 2, 8'h00);
      cfg[0].channel_enable_bit = 1'b1;
      step(8);
      measure(0, 80, 1'b0);
      chk(hi[15:0], c_hi[i][15:0], "high time");
      chk(mx, c_mx[i][15:0], "top count");
    end
    $display("test waveforms done");

    // Double buffering: a period written while running waits for the period end.
    cfg[0] = '{1'b0, 1'b0, 1'b0, 1'b0};
    step(1);
    wr(0, 0, 8'hc8);
    wr(0, 1, 8'h0a);
    cfg[0].channel_enable_bit = 1'b1;
    step(20);
    wr(0, 0, 8'h04);
    step(10);
    chk(cnt_o[0] > 8'h04, 16'h0001, "old period kept");
    wr(0, 2, 8'h5a);
    chk(cnt_o[0] <= 8'h01, 16'h0001, "counter write clears");
    measure(0, 40, 1'b0);
    chk(mx, 16'h0003, "new period after counter write");
    cfg[0].channel_enable_bit = 1'b0;
    step(2);
    snap = cnt_o[0];
    step(10);
    chk(cnt_o[0], snap, "disabled counter stops");
    $display("test buffering done");

    // Joined pair 0/1: 16-bit period 0x0100 and duty 0x0040, low channel in control.
    // The high channel asks for center mode and polarity 1; both must be ignored.
    cat = 4'h1;
    cfg[0] = '{1'b0, 1'b1, 1'b1, 1'b0};
    cfg[1] = '{1'b0, 1'b0, 1'b0, 1'b0};
    step(1);
    wr(0, 0, 8'h01);
    wr(1, 0, 8'h00);
    wr(0, 1, 8'h00);
    wr(1, 1, 8'h40);
    wr(1, 2, 8'h00);
    cfg[1].channel_enable_bit = 1'b1;
    step(8);
    measure(1, 512, 1'b1);
    chk(hi[15:0], 16'd384, "joined high time");
    chk(mx, 16'h00ff, "joined top count");
    chk({en_o[0], en_o[1]}, 16'h0001, "joined enables");
    step(100);
    wr(0, 2, 8'h00);
    chk({cnt_o[0], cnt_o[1]} <= 16'h0001, 16'h0001, "byte write clears pair");
    cfg[1].channel_enable_bit = 1'b0;
    step(2);
    cat = 4'h0;
    $display("test joined pair done");

    // Shutdown: channel 0 set to a constant low so forcing to high is visible.
    cfg[0] = '{1'b0, 1'b0, 1'b0, 1'b0};
    step(1);
    wr(0, 0, 8'h00);
    cfg[0].channel_enable_bit = 1'b1;
    sd_en = 1'h1;
    step(6);
    pin7 = 1'h0;
    step(6);
    chk({flag, irq, sd_act}, 16'h0007, "flag on pin change");
    chk(pin_o[0], 16'h0001, "pins forced");
    irq_en = 1'h0;
    step(1);
    chk({flag, irq}, 16'h0002, "request masked");
    pin7 = 1'h1;
    step(6);
    flag_clr = 1'h1;
    step(1);
    flag_clr = 1'h0;
    step(2);
    chk(flag, 16'h0000, "flag cleared");
    stop_m = 1'h1;
    irq_en = 1'h1;
    step(2);
    pin7 = 1'h0;
    step(6);
    chk({flag, irq}, 16'h0000, "no flag in stop");
    chk(pin_o[0], 16'h0001, "forced in stop");
    // Wait with the halt bit suppresses the flag as stop does.
    stop_m = 1'h0;
    wait_m = 1'h1;
    halt_w = 1'h1;
    pin7 = 1'h1;
    step(6);
    chk({flag, irq}, 16'h0000, "no flag in halted wait");
    // Plain wait flags again; a clear in the cycle of the event loses.
    halt_w = 1'h0;
    pin7 = 1'h0;
    step(2);
    flag_clr = 1'h1;
    step(1);
    flag_clr = 1'h0;
    step(4);
    chk({flag, irq}, 16'h0003, "set wins over clear");
    $display("test shutdown done");
    test_done();
  end
endmodule
`default_nettype wire
